// ---- verilog/occ_pkg.sv ----
// Shared constants, types and helpers of the oscillator control block.
// Assumes a 200 MHz APB clock and a 32.768 kHz low-power clock pin.
// Function
// - Start-up select: off, on, four settling delays.
// - Start commands power oscillator for measurement only.
// - Wait settling delay before starting measurement.
// - Time oscillator start-up from low-power clock.
// - Low-power clock always runs, never gated.
// - Select 7 drives low-power clock on fire pin.
// - Select 7 drives clock/8 on start-enable pin.
// - Calibration command runs calibration with period count.
// - Calibration timed between low-power clock edges.
// - Period count gives 2, 4, 8, 16 periods.
// - Result 16.16 fixed point, divided by divider.
// - Calibration end stores result, sets flag.
package occ_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0C;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;

    typedef struct packed {
        logic [18:0] rsvd;
        logic [2:0] tsto2;
        logic [2:0] tsto1;
        logic [1:0] div;
        logic [1:0] cal_cnt;
        logic [2:0] su;
    } occ_cfg_t;

    typedef struct packed {
        logic [26:0] rsvd;
        logic cal_run;
        logic meas;
        logic settling;
        logic osc_on;
        logic flag;
    } occ_stat_t;

    typedef enum logic [2:0] {
        OCC_OP_NONE = 3'b000,
        OCC_OP_TOF = 3'b001,
        OCC_OP_TOF_RS = 3'b010,
        OCC_OP_TEMP = 3'b011,
        OCC_OP_TEMP_RS = 3'b100,
        OCC_OP_CAL = 3'b101
    } occ_op_t;

    typedef enum logic [2:0] {
        OCC_IDLE = 3'b000,
        OCC_SETTLE = 3'b001,
        OCC_MEAS = 3'b010,
        OCC_CAL_ARM = 3'b011,
        OCC_CAL_RUN = 3'b100
    } occ_state_t;

    // ********************************************************
    // Field codes and timing
    // ********************************************************
    localparam logic [2:0] SU_OFF = 3'h0;
    localparam logic [2:0] SU_CONT = 3'h1;
    localparam logic [2:0] TSTO_LPCLK = 3'h7;
    localparam logic [4:0] CAL_BASE_PERIODS = 5'h02;
    localparam longint LP_HZ = 32768;
    localparam longint NS_PER_S = 1000000000;
    localparam longint SETTLE0_NS = 480000;
    localparam longint SETTLE1_NS = 1460000;
    localparam longint SETTLE2_NS = 2440000;
    localparam longint SETTLE3_NS = 5140000;

    // Least times round up to whole low-power periods
    function automatic logic [7:0] ns_to_lp(input longint ns);
        return 8'((ns * LP_HZ + NS_PER_S - 1) / NS_PER_S);
    endfunction : ns_to_lp

    localparam logic [7:0] SETTLE0_TICKS = ns_to_lp(SETTLE0_NS);
    localparam logic [7:0] SETTLE1_TICKS = ns_to_lp(SETTLE1_NS);
    localparam logic [7:0] SETTLE2_TICKS = ns_to_lp(SETTLE2_NS);
    localparam logic [7:0] SETTLE3_TICKS = ns_to_lp(SETTLE3_NS);

    function automatic logic [7:0] settle_ticks(input logic [2:0] su);
        case (su)
            3'h2: return SETTLE0_TICKS;
            3'h3: return SETTLE1_TICKS;
            3'h4: return SETTLE2_TICKS;
            default: return SETTLE3_TICKS;
        endcase
    endfunction : settle_ticks

    function automatic logic [4:0] cal_periods(input logic [1:0] c);
        return 5'(CAL_BASE_PERIODS << c);
    endfunction : cal_periods

    // Divider code 3 is treated as divide by 4
    function automatic logic [31:0] cal_fix(input logic [15:0] cnt,
                                            input logic [1:0] div);
        logic [1:0] sh;
        sh = (div == 2'h3) ? 2'h2 : div;
        return {cnt, 16'h0000} >> sh;
    endfunction : cal_fix

endpackage : occ_pkg

// ---- verilog/occ_lp_timer.sv ----
// Pin synchronisers and low-power clock events for the oscillator block.
// Assumes both oscillator pins are far slower than pclk.
`timescale 1ns/1ps
module occ_lp_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Oscillator pins
    input wire logic lp_clk_pin,
    input wire logic hs_clk_pin,
    // Events in the pclk domain
    output logic lp_level,
    output logic lp_rise,
    output logic hs_rise,
    output logic lp_div8
);
    import occ_pkg::*;

    logic [2:0] lp_sync_q;
    logic [2:0] hs_sync_q;
    logic [1:0] div_cnt_q;
    logic div8_q;

    // Only the second and third stages are looked at
    assign lp_level = lp_sync_q[1];
    assign lp_rise = lp_sync_q[1] & ~lp_sync_q[2];
    assign hs_rise = hs_sync_q[1] & ~hs_sync_q[2];
    assign lp_div8 = div8_q;

    // No configuration bit gates this path: the low-power clock always runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_sync_q <= 3'h0;
            hs_sync_q <= 3'h0;
        end else if (ce) begin
            lp_sync_q <= {lp_sync_q[1:0], lp_clk_pin};
            hs_sync_q <= {hs_sync_q[1:0], hs_clk_pin};
        end
    end

    // Toggle every fourth rising edge gives clock / 8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 2'h0;
            div8_q <= 1'b0;
        end else if (ce && lp_rise) begin
            div_cnt_q <= div_cnt_q + 2'h1;
            if (div_cnt_q == 2'h3) begin
                div8_q <= ~div8_q;
            end
        end
    end

endmodule : occ_lp_timer

// ---- verilog/occ_ctrl.sv ----
// Oscillator start-up control, clock outputs and resonator calibration.
// Assumes an APB master on pclk and a measuring unit on the same clock.
`timescale 1ns/1ps
module occ_ctrl (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator pins
    input wire logic lp_clk_pin,
    input wire logic hs_clk_pin,
    output logic hs_osc_en,
    // Clock output pins
    output logic fire_in_o,
    output logic fire_in_oe,
    output logic en_start_o,
    output logic en_start_oe,
    // Measuring unit
    output logic meas_start,
    output occ_pkg::occ_op_t meas_op,
    input wire logic meas_done,
    output logic int_flag
);
    import occ_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    occ_cfg_t cfg_q;
    occ_stat_t stat;
    occ_state_t state_q, state_d;
    occ_op_t op_q;
    logic [7:0] settle_q, settle_d;
    logic [4:0] per_q, per_d;
    logic [15:0] hs_cnt_q, hs_cnt_d;
    logic [31:0] result_q, prdata_q;
    logic flag_q, start_q, start_d, done_set;
    logic fire_q, en_start_q;
    logic lp_level, lp_rise, hs_rise, lp_div8;

    occ_lp_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .lp_clk_pin(lp_clk_pin),
        .hs_clk_pin(hs_clk_pin),
        .lp_level(lp_level),
        .lp_rise(lp_rise),
        .hs_rise(hs_rise),
        .lp_div8(lp_div8)
    );

    // ********************************************************
    // APB decode
    // ********************************************************
    wire logic setup = psel & ~penable;
    wire logic access = psel & penable;
    wire logic hit_cfg = paddr == OFS_CFG;
    wire logic hit_cmd = paddr == OFS_CMD;
    wire logic hit_stat = paddr == OFS_STATUS;
    wire logic hit_res = paddr == OFS_RESULT;
    wire logic mapped = hit_cfg | hit_cmd | hit_stat | hit_res;
    wire logic wr = access & pwrite;
    wire logic wr_cfg = wr & hit_cfg;
    wire logic wr_cmd = wr & hit_cmd;
    wire logic wr_stat = wr & hit_stat;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_q;

    wire occ_op_t cmd_op = occ_op_t'(pwdata[2:0]);
    wire logic cmd_legal = cmd_op != OCC_OP_NONE
        && pwdata[2:0] <= OCC_OP_CAL;
    // Commands are refused while a sequence is running
    wire logic cmd_take = wr_cmd & cmd_legal & (state_q == OCC_IDLE);
    wire logic warm = cfg_q.su > SU_CONT;
    wire logic settle_done = settle_q == 8'h00;
    wire logic cal_end = state_q == OCC_CAL_RUN && lp_rise
        && per_q == 5'h01;
    wire logic flag_clr = cmd_take | (wr_stat & pwdata[0]);

    assign stat.rsvd = '0;
    assign stat.cal_run = state_q == OCC_CAL_RUN;
    assign stat.meas = state_q == OCC_MEAS;
    assign stat.settling = state_q == OCC_SETTLE;
    assign stat.osc_on = hs_osc_en;
    assign stat.flag = flag_q;

    wire logic [31:0] rd_mux = hit_cfg ? 32'(cfg_q)
        : hit_stat ? 32'(stat)
        : hit_res ? result_q
        : 32'h0000_0000;

    // ********************************************************
    // Oscillator and pin outputs
    // ********************************************************
    // Demand mode keeps the oscillator on only while busy
    assign hs_osc_en = (cfg_q.su == SU_CONT)
        | (warm & (state_q != OCC_IDLE));
    assign fire_in_oe = cfg_q.tsto1 == TSTO_LPCLK;
    assign en_start_oe = cfg_q.tsto2 == TSTO_LPCLK;
    assign fire_in_o = fire_q;
    assign en_start_o = en_start_q;
    assign meas_start = start_q;
    assign meas_op = op_q;
    assign int_flag = flag_q;

    // ********************************************************
    // Sequencer
    // ********************************************************
    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        per_d = per_q;
        hs_cnt_d = hs_cnt_q;
        start_d = 1'b0;
        done_set = 1'b0;
        unique case (state_q)
            OCC_IDLE: begin
                if (cmd_take) begin
                    // One extra tick covers the partial first period
                    settle_d = 8'(settle_ticks(cfg_q.su) + 8'h01);
                    if (warm) begin
                        state_d = OCC_SETTLE;
                    end else if (cmd_op == OCC_OP_CAL) begin
                        state_d = OCC_CAL_ARM;
                    end else begin
                        state_d = OCC_MEAS;
                        start_d = 1'b1;
                    end
                end
            end
            OCC_SETTLE: begin
                if (settle_done) begin
                    if (op_q == OCC_OP_CAL) begin
                        state_d = OCC_CAL_ARM;
                    end else begin
                        state_d = OCC_MEAS;
                        start_d = 1'b1;
                    end
                end else if (lp_rise) begin
                    settle_d = settle_q - 8'h01;
                end
            end
            OCC_MEAS: begin
                if (meas_done) begin
                    state_d = OCC_IDLE;
                    done_set = 1'b1;
                end
            end
            OCC_CAL_ARM: begin
                // Start event is a low-power clock edge
                if (lp_rise) begin
                    state_d = OCC_CAL_RUN;
                    per_d = cal_periods(cfg_q.cal_cnt);
                    hs_cnt_d = 16'h0000;
                end
            end
            OCC_CAL_RUN: begin
                // Saturates instead of wrapping on a fast resonator
                if (hs_rise && hs_cnt_q != 16'hFFFF) begin
                    hs_cnt_d = hs_cnt_q + 16'h0001;
                end
                if (lp_rise) begin
                    per_d = per_q - 5'h01;
                    if (per_q == 5'h01) begin
                        state_d = OCC_IDLE;
                        done_set = 1'b1;
                    end
                end
            end
            default: state_d = OCC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= OCC_IDLE;
            settle_q <= 8'h00;
            per_q <= 5'h00;
            hs_cnt_q <= 16'h0000;
            start_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            settle_q <= settle_d;
            per_q <= per_d;
            hs_cnt_q <= hs_cnt_d;
            start_q <= start_d;
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= occ_cfg_t'(CFG_RST);
            op_q <= OCC_OP_NONE;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (wr_cfg) begin
                cfg_q <= occ_cfg_t'({19'h0, pwdata[12:0]});
            end
            if (cmd_take) begin
                op_q <= cmd_op;
            end
            if (setup && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // A completion in the clearing cycle still sets the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= RESULT_RST;
            flag_q <= 1'b0;
        end else if (ce) begin
            if (cal_end) begin
                result_q <= cal_fix(hs_cnt_d, cfg_q.div);
            end
            flag_q <= done_set | (flag_q & ~flag_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_q <= 1'b0;
            en_start_q <= 1'b0;
        end else if (ce) begin
            fire_q <= fire_in_oe & lp_level;
            en_start_q <= en_start_oe & lp_div8;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    logic [7:0] seen_q, need_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 8'h00;
            need_q <= 8'h00;
        end else if (ce) begin
            if (cmd_take) begin
                seen_q <= 8'h00;
                need_q <= warm ? settle_ticks(cfg_q.su) : 8'h00;
            end else if (lp_rise && seen_q != 8'hFF) begin
                seen_q <= seen_q + 8'h01;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_off_mode_osc: assert property (
        cfg_q.su == SU_OFF |-> !hs_osc_en)
        else $error("oscillator on while select is off");
    chk_cont_mode_osc: assert property (
        cfg_q.su == SU_CONT |-> hs_osc_en)
        else $error("oscillator off in continuous mode");
    chk_cmd_powers_osc: assert property (
        (cmd_take && warm && ce) |=> hs_osc_en throughout !start_q[*2])
        else $error("oscillator not powered after command");
    chk_settle_before: assert property (
        $rose(start_q) |-> seen_q >= need_q)
        else $error("measurement started before settling delay");
    chk_settle_lp_only: assert property (
        (stat.settling && !lp_rise && !settle_done && ce)
        |=> $stable(settle_q))
        else $error("settling count moved without low-power tick");
    chk_fire_drive: assert property (
        (fire_in_oe && ce) |=> fire_q == $past(lp_level))
        else $error("fire pin not following low-power clock");
    chk_en_start_drive: assert property (
        (en_start_oe && ce) |=> en_start_q == $past(lp_div8))
        else $error("start-enable pin not following clock/8");
    chk_cal_periods: assert property (
        $rose(stat.cal_run) |-> per_q == cal_periods($past(cfg_q.cal_cnt)))
        else $error("calibration period count wrong");
    chk_cal_no_start: assert property (
        stat.cal_run |-> !start_q)
        else $error("measurement start during calibration");
    chk_cal_result: assert property (
        (cal_end && ce) |=> flag_q
        && result_q == cal_fix($past(hs_cnt_d), $past(cfg_q.div)))
        else $error("calibration result or flag not stored");
    chk_osc_off_after: assert property (
        (stat.meas && meas_done && warm && ce) |=> !hs_osc_en)
        else $error("oscillator left on after measurement");

    cov_cal_done: cover property (cal_end && ce);
    cov_meas_done: cover property (stat.meas && meas_done && ce);
    cov_long_settle: cover property (
        stat.settling && settle_done && cfg_q.su == 3'h5);

endmodule : occ_ctrl

// ---- test/occ_far_model.sv ----
// Far-side model: both oscillators and the measuring unit.
// Assumes the block samples the oscillator pins through pclk synchronisers.
`timescale 1ns/1ps
module occ_far_model (
    // Clock
    input wire logic pclk,
    // From the block, and done_dly from the bench
    input wire logic hs_osc_en,
    input wire logic meas_start,
    input wire occ_pkg::occ_op_t meas_op,
    input wire logic [7:0] done_dly,
    // To the block
    output logic lp_clk_pin,
    output logic hs_clk_pin,
    output logic meas_done
);
    import occ_pkg::*;
    logic hs_raw;
    int cnt;
    // ****************
    // Oscillators
    // ****************
    // Fast low-power clock shortens settling; it never stops
    initial begin
        lp_clk_pin = 1'b0;
        forever #80 lp_clk_pin = ~lp_clk_pin;
    end
    // Rises sit 20 ns from low-power rises, so edge counts are exact
    initial begin
        hs_raw = 1'b0;
        forever #20 hs_raw = ~hs_raw;
    end
    // An unpowered oscillator stands still
    assign hs_clk_pin = hs_raw & hs_osc_en;
    // ****************
    // Measuring unit
    // ****************
    initial begin
        meas_done = 1'b0;
        cnt = 0;
    end
    always @(posedge pclk) begin
        meas_done <= 1'b0;
        if (meas_start === 1'b1 && meas_op !== OCC_OP_CAL) begin
            cnt <= int'(done_dly) + 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            meas_done <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : occ_far_model

// ---- test/occ_ctrl_tb.sv ----
// Self-checking bench of the oscillator control block.
// Assumes occ_far_model stands in for oscillators and measuring unit.
`timescale 1ns/1ps
module occ_ctrl_tb;
    import occ_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, done_dly;
    logic [31:0] pwdata, prdata, r;
    logic hs_osc_en, fire_in_o, fire_in_oe, en_start_o, en_start_oe;
    logic meas_start, meas_done, int_flag, lp_clk_pin, hs_clk_pin, e;
    occ_op_t meas_op, op_seen;
    int errors, checked, starts;
    realtime t_start, t_acc;

    occ_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lp_clk_pin(lp_clk_pin),
        .hs_clk_pin(hs_clk_pin), .hs_osc_en(hs_osc_en),
        .fire_in_o(fire_in_o), .fire_in_oe(fire_in_oe),
        .en_start_o(en_start_o), .en_start_oe(en_start_oe),
        .meas_start(meas_start), .meas_op(meas_op),
        .meas_done(meas_done), .int_flag(int_flag));
    occ_far_model far (.pclk(pclk), .hs_osc_en(hs_osc_en),
        .meas_start(meas_start), .meas_op(meas_op), .done_dly(done_dly),
        .lp_clk_pin(lp_clk_pin), .hs_clk_pin(hs_clk_pin),
        .meas_done(meas_done));

    // ****************
    // Helpers
    // ****************
    task automatic test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        checked++;
        if (g !== x) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic chk_t(string n, realtime lo, realtime hi, realtime g);
        checked++;
        if (g < lo || g > hi) begin
            errors++;
            $display("BAD %s expected %0t..%0t seen %0t", n, lo, hi, g);
        end
    endtask : chk_t

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a transfer that is never answered
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        t_acc = $realtime;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(string n, logic [7:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, x, r);
    endtask : rd_chk

    task automatic wait_sig(int s, int lim);
        int n;
        n = 0;
        // The take edge clears the flag late in its own time step
        @(posedge pclk);
        while (n < lim && (s == 0 ? int_flag !== 1'b1 : starts == s)) begin
            @(posedge pclk);
            n++;
        end
        chk("wait done", 1, 32'(n < lim));
    endtask : wait_sig

    // Time between two sampled rises of a clock output pin
    task automatic per(int s, output realtime p);
        int n, k;
        logic pv, cv;
        realtime t;
        n = 0;
        k = 0;
        t = 0;
        pv = 1'b1;
        while (k < 2 && n < 5000) begin
            @(posedge pclk);
            n++;
            cv = s ? en_start_o : fire_in_o;
            if (cv === 1'b1 && pv === 1'b0) begin
                k++;
                if (k == 1)
                    t = $realtime;
            end
            pv = cv;
        end
        p = $realtime - t;
    endtask : per

    always @(posedge pclk) begin
        if (meas_start === 1'b1) begin
            starts++;
            t_start = $realtime;
            op_seen = meas_op;
        end
    end

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        rd_chk("cfg", OFS_CFG, CFG_RST);
        chk("hs_osc_en", 0, hs_osc_en);
        chk("oe", 0, {fire_in_oe, en_start_oe});
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        chk("pslverr", 1, e);
    endtask : t_reset

    task automatic t_cont;
        int s;
        apb(1'b1, OFS_CFG, 32'h0000_0001);
        #1 chk("hs_osc_en", 1, hs_osc_en);
        done_dly <= 8'h05;
        s = starts;
        apb(1'b1, OFS_CMD, 32'h0000_0001);
        wait_sig(0, 2000);
        chk("starts", s + 1, starts);
        chk("int_flag", 1, int_flag);
        chk("hs_osc_en", 1, hs_osc_en);
    endtask : t_cont

    task automatic t_settle;
        int s, us;
        real tk;
        occ_op_t op;
        for (int su = 2; su < 8; su++) begin
            op = occ_op_t'(3'((su - 2) % 4 + 1));
            us = su == 2 ? 480 : su == 3 ? 1460 : su == 4 ? 2440 : 5140;
            tk = $ceil(us * 32768.0 / 1.0e6) * 160.0;
            apb(1'b1, OFS_CFG, 32'(su));
            #1 chk("hs_osc_en", 0, hs_osc_en);
            s = starts;
            apb(1'b1, OFS_CMD, 32'(op));
            #1 chk("hs_osc_en", 1, hs_osc_en);
            wait_sig(s, 40000);
            chk_t("settle", tk, tk + 370.0, t_start - t_acc);
            chk("meas_op", 32'(op), 32'(op_seen));
            wait_sig(0, 2000);
            repeat (2) @(posedge pclk);
            #1 chk("hs_osc_en", 0, hs_osc_en);
        end
    endtask : t_settle

    task automatic t_cal;
        logic [31:0] x;
        apb(1'b1, OFS_CFG, 32'h0000_0001);
        for (int c = 0; c < 4; c++) begin
            // Four fast-clock rises per low-power period in this bench
            x = (32'(4 * (2 << c)) << 16) >> (c == 3 ? 2 : c);
            apb(1'b1, OFS_CFG, 32'(1 + (c << 3) + (c << 5)));
            apb(1'b1, OFS_CMD, 32'h0000_0005);
            wait_sig(0, 4000);
            chk("cal flag", 1, int_flag);
            rd_chk("result", OFS_RESULT, x);
        end
    endtask : t_cal

    task automatic t_refuse;
        int s;
        done_dly <= 8'hC8;
        s = starts;
        apb(1'b1, OFS_CMD, 32'h0000_0001);
        apb(1'b1, OFS_CMD, 32'h0000_0003);
        rd_chk("status busy", OFS_STATUS, 32'h0000_0006);
        wait_sig(0, 8000);
        chk("busy cmd", s + 1, starts);
        chk("meas_op", 32'(OCC_OP_TOF), 32'(op_seen));
        for (int i = 5; i < 8; i++) begin
            apb(1'b1, OFS_CMD, i == 5 ? 32'h0000_0000 : 32'(i));
            repeat (30) @(posedge pclk);
            chk("bad op", s + 1, starts);
        end
        chk("int_flag", 1, int_flag);
        apb(1'b1, OFS_STATUS, 32'h0000_0001);
        #1 chk("flag clear", 0, int_flag);
        rd_chk("status idle", OFS_STATUS, 32'h0000_0000);
        rd_chk("cmd read", OFS_CMD, 32'h0000_0000);
        apb(1'b1, OFS_CFG, 32'hFFFF_FFFF);
        rd_chk("cfg bits", OFS_CFG, 32'h0000_1FFF);
    endtask : t_refuse

    task automatic t_clkout;
        realtime p;
        logic seen;
        apb(1'b1, OFS_CFG, 32'h0000_1F80);
        #1 chk("oe", 3, {fire_in_oe, en_start_oe});
        per(0, p);
        chk_t("lp out", 155.0, 165.0, p);
        per(1, p);
        chk_t("lp/8 out", 1275.0, 1285.0, p);
        apb(1'b1, OFS_CFG, 32'h0000_1B00);
        // The pin registers still hold the old select for one cycle
        @(posedge pclk);
        seen = 1'b0;
        repeat (60) begin
            @(posedge pclk);
            seen = seen | fire_in_o | fire_in_oe | en_start_o | en_start_oe;
        end
        chk("sel 6", 0, seen);
    endtask : t_clkout

    // ****************
    // Main sequence
    // ****************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        #400us;
        errors++;
        test_done;
    end

    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        done_dly = 8'h05;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_cont;
        t_settle;
        t_refuse;
        t_clkout;
        t_cal;
        test_done;
    end
endmodule : occ_ctrl_tb
